// file: src/ace_pkg.sv
// constants shared by the comparator event conditioning block
// assumes byte addressing on a 32-bit apb bus, one word per register
package ace_pkg;

  localparam int          ACE_NUM_CMP       = 3;
  localparam logic [11:0] ACE_CTL0_OFFSET   = 12'h024;
  localparam logic [11:0] ACE_CTL1_OFFSET   = 12'h044;
  localparam logic [11:0] ACE_CTL2_OFFSET   = 12'h064;
  localparam logic [11:0] ACE_STATUS_OFFSET = 12'h080;
  localparam logic [31:0] ACE_CTL_RESET     = 32'h0000_0000;
  localparam logic [31:0] ACE_CTL_WMASK     = 32'h0000_0EFE;

  localparam int ACE_OUTPUT_INVERT_BIT   = 1;
  localparam int ACE_INT_SENSE_LSB       = 2;
  localparam int ACE_INT_LEVEL_BIT       = 4;
  localparam int ACE_TRIG_SENSE_LSB      = 5;
  localparam int ACE_TRIG_LEVEL_BIT      = 7;
  localparam int ACE_REF_SELECT_LSB      = 9;
  localparam int ACE_TRIG_OUT_EN_BIT     = 11;

  typedef enum logic [1:0] {
    ACE_SENSE_LEVEL   = 2'h0,
    ACE_SENSE_FALLING = 2'h1,
    ACE_SENSE_RISING  = 2'h2,
    ACE_SENSE_EITHER  = 2'h3
  } ace_sense_e;

endpackage : ace_pkg

// file: src/ace_sense.sv
// one sense selector: level with polarity, falling, rising or either edge
// assumes cond and prev are synchronous samples on clock
`timescale 1ns/1ps
`default_nettype none
module ace_sense
  import ace_pkg::*;
(
  input  wire logic       cond,     // conditioned comparator level
  input  wire logic       prev,     // previous sample of cond
  input  wire logic [1:0] sense,    // sense selection field
  input  wire logic       level,    // polarity for level sense
  output logic            event_o   // qualified event
);
  import ace_pkg::*;

  always_comb
  begin
    case (ace_sense_e'(sense))
      ACE_SENSE_LEVEL:   event_o = (cond == level);
      ACE_SENSE_FALLING: event_o = prev & ~cond;
      ACE_SENSE_RISING:  event_o = ~prev & cond;
      default:           event_o = prev ^ cond;
    endcase
  end
endmodule : ace_sense
`default_nettype wire

// file: src/ace_channel.sv
// one comparator channel: invert, edge sampling, interrupt and trigger sense
// assumes cmp_raw is synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module ace_channel
  import ace_pkg::*;
(
  input  wire logic        clock,    // system clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire logic        cmp_raw,  // raw comparator output
  input  wire logic [31:0] ctl,      // control register value
  output logic             irq,      // interrupt request
  output logic             trig      // converter trigger event
);
  import ace_pkg::*;

  logic cond;
  logic prev_q;
  logic prev_d;
  logic trig_raw;

  // inversion precedes every conditioning path
  assign cond = cmp_raw ^ ctl[ACE_OUTPUT_INVERT_BIT]; // RL6

  always_comb
  begin
    prev_d = cond;
  end

  // previous sample feeds edge compare, one-cycle events
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 1'b0;
    else
      prev_q <= prev_d; // RL9
  end

  ace_sense u_int_sense (
    .cond    (cond),
    .prev    (prev_q),
    .sense   (ctl[ACE_INT_SENSE_LSB+:2]),  // RL5
    .level   (ctl[ACE_INT_LEVEL_BIT]),     // RL4
    .event_o (irq)
  );

  ace_sense u_trig_sense (
    .cond    (cond),
    .prev    (prev_q),
    .sense   (ctl[ACE_TRIG_SENSE_LSB+:2]), // RL3
    .level   (ctl[ACE_TRIG_LEVEL_BIT]),    // RL2
    .event_o (trig_raw)
  );

  assign trig = trig_raw & ctl[ACE_TRIG_OUT_EN_BIT]; // RL1

  a_trig_gate: assert property (@(posedge clock) disable iff (!rst_n) // RL1
    !ctl[ACE_TRIG_OUT_EN_BIT] |-> !trig)
    else $error("trigger passed while disabled");
  a_trig_level: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    (ctl[ACE_TRIG_SENSE_LSB+:2] == ACE_SENSE_LEVEL && ctl[ACE_TRIG_OUT_EN_BIT])
    |-> (trig == (cond == ctl[ACE_TRIG_LEVEL_BIT])))
    else $error("level trigger wrong");
  a_trig_rise: assert property (@(posedge clock) disable iff (!rst_n) // RL3
    (ctl[ACE_TRIG_SENSE_LSB+:2] == ACE_SENSE_RISING && ctl[ACE_TRIG_OUT_EN_BIT]
     && $rose(cond) && $stable(ctl)) |-> trig)
    else $error("rising trigger missed");
  a_irq_level: assert property (@(posedge clock) disable iff (!rst_n) // RL4
    (ctl[ACE_INT_SENSE_LSB+:2] == ACE_SENSE_LEVEL)
    |-> (irq == (cond == ctl[ACE_INT_LEVEL_BIT])))
    else $error("level irq wrong");
  a_irq_fall: assert property (@(posedge clock) disable iff (!rst_n) // RL5
    (ctl[ACE_INT_SENSE_LSB+:2] == ACE_SENSE_FALLING
     && $fell(cond) && $stable(ctl)) |-> irq)
    else $error("falling irq missed");
  // the pulse must drop once input and setup rest for one cycle
  a_irq_edge_pulse: assert property (@(posedge clock) disable iff (!rst_n) // RL9
    (ctl[ACE_INT_SENSE_LSB+:2] == ACE_SENSE_EITHER && irq
     ##1 ($stable(cmp_raw) && $stable(ctl))) |-> !irq)
    else $error("edge irq longer than one cycle");
  a_invert_path: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    (ctl[ACE_INT_SENSE_LSB+:2] == ACE_SENSE_LEVEL && ctl[ACE_INT_LEVEL_BIT]
     && ctl[ACE_OUTPUT_INVERT_BIT]) |-> (irq == !cmp_raw))
    else $error("inversion not applied");
endmodule : ace_channel
`default_nettype wire

// file: src/ace_top.sv
// comparator event conditioning: three channels behind an apb slave
// assumes comparator outputs are synchronous to clock; no wait states
//
// Contract
// [RL1] trigger enable clear suppresses all converter triggers; set passes them
// [RL2] level trigger fires while conditioned output equals trigger polarity bit
// [RL3] trigger sense: 0 level, 1 falling, 2 rising, 3 either edge
// [RL4] level interrupt asserts while conditioned output equals interrupt polarity bit
// [RL5] interrupt sense: 0 level, 1 falling, 2 rising, 3 either edge
// [RL6] invert bit flips raw comparator output before all conditioning
// [RL7] reserved control bits read zero and ignore writes
// [RL8] three control registers at 0x024, 0x044, 0x064, reset to zero
// [RL9] edges found by comparing with previous clocked sample, one-cycle events
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ace_top
  import ace_pkg::*;
(
  input  wire logic                   clock,    // system clock, 50 MHz
  input  wire logic                   rst_n,    // async reset, active low
  input  wire logic                   psel,     // apb select
  input  wire logic                   penable,  // apb enable
  input  wire logic                   pwrite,   // apb direction
  input  wire logic [11:0]            paddr,    // apb byte address
  input  wire logic [31:0]            pwdata,   // apb write data
  output logic                        pready,   // apb ready
  output logic [31:0]                 prdata,   // apb read data, registered
  output logic                        pslverr,  // apb error, unmapped address
  input  wire logic [ACE_NUM_CMP-1:0] cmp_raw,  // raw comparator outputs
  output logic [ACE_NUM_CMP-1:0]      irq,      // interrupt requests
  output logic [ACE_NUM_CMP-1:0]      trig,     // converter trigger events
  output logic [1:0]                  ref_sel0, // reference select, comparator 0
  output logic [1:0]                  ref_sel1, // reference select, comparator 1
  output logic [1:0]                  ref_sel2  // reference select, comparator 2
);
  import ace_pkg::*;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [31:0] ctl_q [ACE_NUM_CMP];
  logic [31:0] ctl_d [ACE_NUM_CMP];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        setup;
  logic [1:0]  sel_idx;
  logic        sel_ctl;
  logic        sel_status;
  logic [31:0] status_word;

  // answer comes in the access phase after a setup cycle, no waits
  assign setup  = psel & ~penable;
  assign pready = 1'b1;

  // live event levels, sampled into the read register at setup
  assign status_word = {26'h0, trig, irq};

  always_comb
  begin
    sel_idx    = 2'h0;
    sel_ctl    = 1'b0;
    sel_status = 1'b0;
    if (paddr == ACE_CTL0_OFFSET) // RL8
    begin
      sel_ctl = 1'b1;
      sel_idx = 2'h0;
    end
    else if (paddr == ACE_CTL1_OFFSET)
    begin
      sel_ctl = 1'b1;
      sel_idx = 2'h1;
    end
    else if (paddr == ACE_CTL2_OFFSET)
    begin
      sel_ctl = 1'b1;
      sel_idx = 2'h2;
    end
    else if (paddr == ACE_STATUS_OFFSET)
    begin
      sel_status = 1'b1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < ACE_NUM_CMP; i++)
    begin
      ctl_d[i] = ctl_q[i];
    end
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup)
    begin
      err_d   = ~(sel_ctl | sel_status);
      rdata_d = 32'h0000_0000;
      if (!pwrite && sel_ctl)
        rdata_d = ctl_q[sel_idx];
      else if (!pwrite && sel_status)
        rdata_d = status_word;
    end
    // write lands at the completing edge; reserved bits masked off
    if (psel && penable && pwrite && sel_ctl)
      ctl_d[sel_idx] = pwdata & ACE_CTL_WMASK; // RL7
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < ACE_NUM_CMP; i++)
      begin
        ctl_q[i] <= ACE_CTL_RESET; // RL8
      end
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < ACE_NUM_CMP; i++)
      begin
        ctl_q[i] <= ctl_d[i];
      end
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign prdata   = rdata_q;
  assign pslverr  = err_q & psel & penable;
  assign ref_sel0 = ctl_q[0][ACE_REF_SELECT_LSB+:2];
  assign ref_sel1 = ctl_q[1][ACE_REF_SELECT_LSB+:2];
  assign ref_sel2 = ctl_q[2][ACE_REF_SELECT_LSB+:2];

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar g = 0; g < ACE_NUM_CMP; g++)
  begin : g_ch
    ace_channel u_ch (
      .clock   (clock),
      .rst_n   (rst_n),
      .cmp_raw (cmp_raw[g]),
      .ctl     (ctl_q[g]),
      .irq     (irq[g]),
      .trig    (trig[g])
    );
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    (ctl_q[0] & ~ACE_CTL_WMASK) == 32'h0)
    else $error("reserved bits set");
  a_reserved_one: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    (ctl_q[1] & ~ACE_CTL_WMASK) == 32'h0)
    else $error("reserved bits set");
  a_reserved_two: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    (ctl_q[2] & ~ACE_CTL_WMASK) == 32'h0)
    else $error("reserved bits set");
  a_write_ch0: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && penable && pwrite && paddr == ACE_CTL0_OFFSET)
    |=> ctl_q[0] == ($past(pwdata) & ACE_CTL_WMASK))
    else $error("write lost");
  a_write_lands: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && penable && pwrite && paddr == ACE_CTL1_OFFSET)
    |=> ctl_q[1] == ($past(pwdata) & ACE_CTL_WMASK))
    else $error("write lost");
  a_write_ch2: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && penable && pwrite && paddr == ACE_CTL2_OFFSET)
    |=> ctl_q[2] == ($past(pwdata) & ACE_CTL_WMASK))
    else $error("write lost");
  // reads, status writes and stray addresses leave the setup words alone
  a_ctl_hold: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    !(psel && penable && pwrite && sel_ctl)
    |=> ($stable(ctl_q[0]) && $stable(ctl_q[1]) && $stable(ctl_q[2])))
    else $error("control changed without a write");

  // ------------------------------------------------------------
  // checks: read path and error response
  // ------------------------------------------------------------
  a_read_ch0: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && !pwrite && paddr == ACE_CTL0_OFFSET)
    |=> prdata == $past(ctl_q[0]))
    else $error("control read wrong");
  a_read_ch1: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && !pwrite && paddr == ACE_CTL1_OFFSET)
    |=> prdata == $past(ctl_q[1]))
    else $error("control read wrong");
  a_read_ch2: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && !pwrite && paddr == ACE_CTL2_OFFSET)
    |=> prdata == $past(ctl_q[2]))
    else $error("control read wrong");
  a_read_status: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && sel_status)
    |=> prdata == $past(status_word))
    else $error("status read wrong");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && !sel_ctl && !sel_status)
    |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_unmapped_err: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && !sel_ctl && !sel_status) ##1 (psel && penable)
    |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (psel && !penable && (sel_ctl || sel_status)) ##1 (psel && penable)
    |-> !pslverr)
    else $error("mapped access flagged as error");
endmodule : ace_top
`default_nettype wire

// file: testbench/ace_cmp_model.sv
// comparator stand-in: turns a commanded level into a clocked output
// assumes the bench moves level right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ace_cmp_model
(
  input  wire logic       clock,   // system clock
  input  wire logic [2:0] level,   // commanded comparator state
  output logic      [2:0] cmp_raw  // synchronous comparator output
);
  // the block expects outputs already settled to its clock
  always_ff @(posedge clock)
  begin
    cmp_raw <= level;
  end
endmodule : ace_cmp_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the comparator event conditioning block
// assumes one 50 MHz clock and an apb slave with no wait states
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ace_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr;
  logic [2:0]  lvl, cmp_raw, irq, trig;
  logic [1:0]  ref_sel0, ref_sel1, ref_sel2;
  int          fails, cmp_count;
  // row: control, level before, level after, pulse irq/trig, steady irq/trig
  logic [17:0] rows [11];

  ace_cmp_model u_ace_cmp_model (.clock(clock), .level(lvl), .cmp_raw(cmp_raw));
  ace_top u_ace_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .irq(irq), .trig(trig), .ref_sel0(ref_sel0),
    .ref_sel1(ref_sel1), .ref_sel2(ref_sel2));

  always #10 clock = ~clock;

  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  // caller enters right after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  initial
  begin
    rows = '{{12'h000, 6'h2A}, {12'h800, 6'h2F}, {12'h890, 6'h1F}, {12'h824, 6'h2C},
             {12'h848, 6'h1C}, {12'h848, 6'h20}, {12'h86C, 6'h2C}, {12'h86C, 6'h1C},
             {12'h84A, 6'h2C}, {12'h048, 6'h18}, {12'h890, 6'h20}};
    clock = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0; lvl = 3'h0; fails = 0; cmp_count = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, ACE_CTL0_OFFSET, 32'h0);
    chk("ctl0_reset", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, ACE_CTL2_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, ACE_CTL2_OFFSET, 32'h0);
    chk("ctl2_reserved", 32'h0000_0EFE, rd);
    chk("ref_sel", 32'h30, {26'h0, ref_sel2, ref_sel1, ref_sel0});
    for (int i = 0; i < 11; i++)
    begin
      lvl <= {3{rows[i][5]}};
      for (int j = 0; j < 3; j++)
        apb(1'b1, ACE_CTL0_OFFSET + 12'(j * 32), {20'h0, rows[i][17:6]});
      lvl <= {3{rows[i][4]}};
      // model adds one edge; the pulse stands in the cycle after it
      @(posedge clock);
      #1;
      chk("irq_pulse", {29'h0, {3{rows[i][3]}}}, {29'h0, irq});
      chk("trig_pulse", {29'h0, {3{rows[i][2]}}}, {29'h0, trig});
      @(posedge clock);
      #1;
      chk("irq_steady", {29'h0, {3{rows[i][1]}}}, {29'h0, irq});
      chk("trig_steady", {29'h0, {3{rows[i][0]}}}, {29'h0, trig});
      @(posedge clock);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, ACE_CTL1_OFFSET, 32'h0);
    chk("ctl1_rereset", 32'h0, rd);
    apb(1'b0, ACE_STATUS_OFFSET, 32'h0);
    chk("status_rereset", 32'h7, rd);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
